// ==== cpm_pkg.sv ====
/*
 * package of the core performance monitor: register pair codes, control field
 * positions, reset values and the rate divider count.
 * assumes the core presents decoded coprocessor-14 register moves.
 */
// Summary of operation
// - four 32-bit event counters and one 32-bit cycle counter run together.
// - occurrence events add one per event; duration events add one per clock held.
// - counters keep counting after overflow until the monitor is disabled.
// - each of five counters has its own overflow interrupt enable.
// - registers reached only by privileged coprocessor-14 moves; user access ignored.
// - decode by register pair: secondary 1 for control group, 2 for event counters.
// - control bit 2 written one clears cycle counter; counter also directly writable.
// - cycle counter wraps after all-ones, sets flag bit 0, interrupts if enabled.
// - control bit 1 written one clears all event counters; each directly writable.
// - event counter wraps on event after all-ones, sets flag bits 1 to 4.
// - control bits 31:24 read a fixed identifier and ignore writes.
// - control bit 3 set makes the cycle counter advance once per 64 clocks.
// - reset clears the global enable; other state need not be defined.
// - one global enable bit switches the whole counting mechanism.
// - global enable is control bit 0; cleared stops all five counters.
// - writing one to a flag clears it; request persists until flag or enable cleared.
// - clearing the global enable does not withdraw a pending request.
package cpm_pkg;
    localparam int unsigned NUM_EVT = 4;
    localparam int unsigned NUM_CNT = 5;
    localparam logic [3:0] SEC_CTRL_GROUP = 4'h1;
    localparam logic [3:0] SEC_EVT_GROUP = 4'h2;
    localparam logic [3:0] PRI_CONTROL = 4'h0;
    localparam logic [3:0] PRI_CYCLE = 4'h1;
    localparam logic [3:0] PRI_IRQ_EN = 4'h4;
    localparam logic [3:0] PRI_FLAGS = 4'h5;
    localparam logic [3:0] PRI_EVT_SEL = 4'h8;
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_EVT_RESET = 1;
    localparam int unsigned CTL_CYC_RESET = 2;
    localparam int unsigned CTL_DIVIDE = 3;
    localparam int unsigned CTL_ID_LSB = 24;
    localparam int unsigned SEL_WIDTH = 8;
    // unit identifier value is arbitrary
    localparam logic [7:0] UNIT_ID = 8'h5A;
    localparam logic [5:0] DIV_LAST = 6'h3F;
    localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;
    localparam logic [31:0] CNT_ZERO = 32'h00000000;
    localparam logic [4:0] FIVE_ZERO = 5'h00;
    localparam logic [5:0] DIV_ZERO = 6'h00;
endpackage : cpm_pkg

// ==== cpm_count_if.sv ====
/*
 * interface carrying one event counter's controls and status.
 * assumes the owner drives controls and the counter drives status.
 */
`timescale 1ns/1ps
interface cpm_count_if;
    logic run;
    logic clear;
    logic load;
    logic [31:0] load_value;
    logic event_hit;
    logic [31:0] value;
    logic wrapped;
    modport owner (output run, output clear, output load, output load_value,
        output event_hit, input value, input wrapped);
    modport counter (input run, input clear, input load, input load_value,
        input event_hit, output value, output wrapped);
endinterface : cpm_count_if

// ==== cpm_event_counter.sv ====
/*
 * one 32-bit event counter with clear, load and wrap detection.
 * assumes single clock mclk_i and synchronous reset rst_i.
 */
`timescale 1ns/1ps
module cpm_event_counter (
    input wire logic mclk_i,
    input wire logic rst_i,
    cpm_count_if.counter cnt
);
    logic [31:0] value;
    logic wrapped;

    assign cnt.value = value;
    assign cnt.wrapped = wrapped;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            value <= cpm_pkg::CNT_ZERO;
        end else if (cnt.clear) begin
            value <= cpm_pkg::CNT_ZERO;
        end else if (cnt.load) begin
            value <= cnt.load_value;
        end else if (cnt.run && cnt.event_hit) begin
            value <= value + 32'h00000001;
        end
    end

    // single-cycle pulse when the counter rolls from all-ones to zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wrapped <= 1'b0;
        end else begin
            wrapped <= !cnt.clear && !cnt.load && cnt.run && cnt.event_hit
                && (value == cpm_pkg::CNT_MAX);
        end
    end
endmodule : cpm_event_counter

// ==== cpm_monitor.sv ====
/*
 * core performance monitor: cycle counter, four event counters, control,
 * interrupt enable, overflow flags and event selection on coprocessor moves.
 * assumes the core decodes coprocessor-14 moves into cp_* strobes with
 * register pair and privilege level, and supplies event lines on mclk_i.
 */
`timescale 1ns/1ps
module cpm_monitor (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cp_write_i,
    input wire logic cp_read_i,
    input wire logic cp_privileged_i,
    input wire logic [3:0] cp_primary_i,
    input wire logic [3:0] cp_secondary_i,
    input wire logic [31:0] cp_wdata_i,
    output logic [31:0] cp_rdata_o,
    output logic cp_rvalid_o,
    input wire logic [255:0] event_lines_i,
    output logic irq_o
);
    typedef enum logic [2:0] {
        REG_NONE = 3'h1,
        REG_HIT = 3'h2,
        REG_EVT = 3'h4
    } cpm_group_t;

    logic enable;
    logic divide;
    logic [31:0] cycle_count;
    logic [5:0] divider;
    logic [4:0] irq_enable;
    logic [4:0] flags;
    logic [31:0] event_select;
    logic cycle_wrap;
    logic [3:0] evt_wrap;
    logic [31:0] evt_value [cpm_pkg::NUM_EVT];
    logic [31:0] next_rdata;
    logic acc_ok;
    logic wr_ok;
    cpm_group_t group;

    // privileged accesses only; user-mode moves read as nothing and write nothing
    assign acc_ok = cp_privileged_i;
    assign wr_ok = cp_write_i && acc_ok;

    function automatic logic hit_ctrl(input logic [3:0] pri, input logic [3:0] sec,
        input logic [3:0] want);
        hit_ctrl = (sec == cpm_pkg::SEC_CTRL_GROUP) && (pri == want);
    endfunction : hit_ctrl

    function automatic logic hit_evt(input logic [3:0] pri, input logic [3:0] sec,
        input int unsigned idx);
        hit_evt = (sec == cpm_pkg::SEC_EVT_GROUP) && (pri == idx[3:0]);
    endfunction : hit_evt

    always_comb begin
        if (cp_secondary_i == cpm_pkg::SEC_EVT_GROUP && cp_primary_i < 4'h4) begin
            group = REG_EVT;
        end else if (cp_secondary_i == cpm_pkg::SEC_CTRL_GROUP) begin
            group = REG_HIT;
        end else begin
            group = REG_NONE;
        end
    end

    // control: global enable and divider; reset bits are pulses and not stored
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            enable <= 1'b0;
            divide <= 1'b0;
        end else if (wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_CONTROL)) begin
            enable <= cp_wdata_i[cpm_pkg::CTL_ENABLE];
            divide <= cp_wdata_i[cpm_pkg::CTL_DIVIDE];
        end
    end

    logic ctrl_wr;
    assign ctrl_wr = wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_CONTROL);

    // prescaler for the divide-by-64 mode; restarts with the counter clear
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            divider <= cpm_pkg::DIV_ZERO;
        end else if (ctrl_wr && cp_wdata_i[cpm_pkg::CTL_CYC_RESET]) begin
            divider <= cpm_pkg::DIV_ZERO;
        end else if (enable) begin
            divider <= divider + 6'h01;
        end
    end

    logic cycle_tick;
    assign cycle_tick = enable && (!divide || divider == cpm_pkg::DIV_LAST);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cycle_count <= cpm_pkg::CNT_ZERO;
        end else if (ctrl_wr && cp_wdata_i[cpm_pkg::CTL_CYC_RESET]) begin
            cycle_count <= cpm_pkg::CNT_ZERO;
        end else if (wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_CYCLE)) begin
            cycle_count <= cp_wdata_i;
        end else if (cycle_tick) begin
            cycle_count <= cycle_count + 32'h00000001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cycle_wrap <= 1'b0;
        end else begin
            cycle_wrap <= !(ctrl_wr && cp_wdata_i[cpm_pkg::CTL_CYC_RESET])
                && !(wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_CYCLE))
                && cycle_tick && (cycle_count == cpm_pkg::CNT_MAX);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_enable <= cpm_pkg::FIVE_ZERO;
        end else if (wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_IRQ_EN)) begin
            irq_enable <= cp_wdata_i[4:0];
        end
    end

    // selection may change any time; software is expected to disable first
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            event_select <= cpm_pkg::CNT_ZERO;
        end else if (wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_EVT_SEL)) begin
            event_select <= cp_wdata_i;
        end
    end

    // a wrap in the same cycle as a write-one clear keeps the flag set
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags <= cpm_pkg::FIVE_ZERO;
        end else begin
            if (wr_ok && hit_ctrl(cp_primary_i, cp_secondary_i, cpm_pkg::PRI_FLAGS)) begin
                flags <= (flags & ~cp_wdata_i[4:0]) | {evt_wrap, cycle_wrap};
            end else begin
                flags <= flags | {evt_wrap, cycle_wrap};
            end
        end
    end

    // not gated by the global enable, so disabling leaves a request standing
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags & irq_enable);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < cpm_pkg::NUM_EVT; gi++) begin : g_evt
            cpm_count_if link ();
            logic [7:0] sel;
            assign sel = event_select[gi*cpm_pkg::SEL_WIDTH +: cpm_pkg::SEL_WIDTH];
            // the core shapes each line: pulse per occurrence, level for duration
            assign link.event_hit = event_lines_i[sel];
            assign link.run = enable;
            assign link.clear = ctrl_wr && cp_wdata_i[cpm_pkg::CTL_EVT_RESET];
            assign link.load = wr_ok && hit_evt(cp_primary_i, cp_secondary_i, gi);
            assign link.load_value = cp_wdata_i;
            assign evt_value[gi] = link.value;
            assign evt_wrap[gi] = link.wrapped;
            cpm_event_counter u_cnt (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .cnt(link.counter)
            );
        end
    endgenerate

    always_comb begin
        next_rdata = cpm_pkg::CNT_ZERO;
        case (group)
            REG_EVT: begin
                next_rdata = evt_value[cp_primary_i[1:0]];
            end
            REG_HIT: begin
                case (cp_primary_i)
                    cpm_pkg::PRI_CONTROL: begin
                        next_rdata[31:cpm_pkg::CTL_ID_LSB] = cpm_pkg::UNIT_ID;
                        next_rdata[cpm_pkg::CTL_DIVIDE] = divide;
                        next_rdata[cpm_pkg::CTL_ENABLE] = enable;
                    end
                    cpm_pkg::PRI_CYCLE: next_rdata = cycle_count;
                    cpm_pkg::PRI_IRQ_EN: next_rdata[4:0] = irq_enable;
                    cpm_pkg::PRI_FLAGS: next_rdata[4:0] = flags;
                    cpm_pkg::PRI_EVT_SEL: next_rdata = event_select;
                    default: next_rdata = cpm_pkg::CNT_ZERO;
                endcase
            end
            default: next_rdata = cpm_pkg::CNT_ZERO;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cp_rdata_o <= cpm_pkg::CNT_ZERO;
            cp_rvalid_o <= 1'b0;
        end else begin
            cp_rvalid_o <= cp_read_i && acc_ok;
            if (cp_read_i && acc_ok) begin
                cp_rdata_o <= next_rdata;
            end
        end
    end
endmodule : cpm_monitor

// ==== cpm_monitor_checker.sv ====
/* checker for cpm_monitor: read answers, field read-back and request hold.
   assumes it is bound to cpm_monitor and sees only that module's ports. */
`timescale 1ns/1ps
module cpm_monitor_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cp_write_i,
    input wire logic cp_read_i,
    input wire logic cp_privileged_i,
    input wire logic [3:0] cp_primary_i,
    input wire logic [3:0] cp_secondary_i,
    input wire logic [31:0] cp_rdata_o,
    input wire logic cp_rvalid_o,
    input wire logic irq_o
);
    logic rd_ok;
    logic ctl_rd;
    logic ctl0;
    logic flag_wr;
    assign rd_ok = cp_read_i && cp_privileged_i;
    assign ctl_rd = rd_ok && cp_secondary_i == 4'h1;
    assign ctl0 = ctl_rd && cp_primary_i == 4'h0;
    // only enable or flag writes may drop a pending request
    assign flag_wr = cp_write_i && cp_privileged_i && cp_secondary_i == 4'h1
        && cp_primary_i[3:1] == 3'h2;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    chk_read_answered: assert property (rd_ok |=> cp_rvalid_o)
        else $error("read not answered");
    chk_user_ignored: assert property (!rd_ok |=> !cp_rvalid_o)
        else $error("answer without privileged read");
    chk_rdata_holds: assert property (!cp_rvalid_o |-> $stable(cp_rdata_o))
        else $error("read data moved without answer");
    chk_unit_id: assert property (ctl0 |=> cp_rdata_o[31:24] == cpm_pkg::UNIT_ID)
        else $error("identifier field wrong");
    chk_reset_bits: assert property (ctl0 |=> cp_rdata_o[2:1] == 2'h0)
        else $error("clear command bits read back set");
    chk_status_upper: assert property (ctl_rd && cp_primary_i[3:1] == 3'h2
        |=> cp_rdata_o[31:5] == 27'h0)
        else $error("enable or flag upper bits set");
    chk_unmapped_zero: assert property (rd_ok && !(cp_secondary_i inside {4'h1, 4'h2})
        |=> cp_rdata_o == 32'h0)
        else $error("unmapped pair read nonzero");
    chk_irq_persists: assert property (irq_o && !flag_wr && !$past(flag_wr)
        |=> irq_o)
        else $error("request dropped without flag or enable write");
    cov_read: cover property (rd_ok);
    cov_user_move: cover property ((cp_read_i || cp_write_i) && !cp_privileged_i);
    cov_irq_up: cover property ($rose(irq_o));
    cov_irq_down: cover property ($fell(irq_o));
endmodule : cpm_monitor_checker

// ==== cpm_core_model.sv ====
/* core model: register moves and event lines toward cpm_monitor.
   assumes one clock; moves launch just after a rising edge. */
`timescale 1ns/1ps
module cpm_core_model (
    input wire logic mclk_i,
    output logic cp_write_o,
    output logic cp_read_o,
    output logic cp_privileged_o,
    output logic [3:0] cp_primary_o,
    output logic [3:0] cp_secondary_o,
    output logic [31:0] cp_wdata_o,
    output logic [255:0] cp_events_o
);
    initial begin
        cp_write_o = 1'b0;
        cp_read_o = 1'b0;
        cp_privileged_o = 1'b0;
        cp_primary_o = 4'h0;
        cp_secondary_o = 4'h0;
        cp_wdata_o = 32'h0;
        cp_events_o = 256'h0;
    end
    // only register move forms, never coprocessor loads or stores
    task automatic move(input logic wr, input logic priv, input logic [3:0] pri,
            input logic [3:0] sec, input logic [31:0] data);
        @(posedge mclk_i);
        cp_write_o <= wr;
        cp_read_o <= !wr;
        cp_privileged_o <= priv;
        cp_primary_o <= pri;
        cp_secondary_o <= sec;
        cp_wdata_o <= data;
        @(posedge mclk_i);
        cp_write_o <= 1'b0;
        cp_read_o <= 1'b0;
        // released data is scrambled so a late sample cannot pass by luck
        cp_wdata_o <= ~data;
        #1;
    endtask : move
endmodule : cpm_core_model

// ==== tb_core_performance_monitor.sv ====
/* testbench for cpm_monitor: register moves issued through the core model.
   assumes the checker is bound below and the model drives the move and event inputs; clock and reset come from the testbench. */
`timescale 1ns/1ps
module tb_core_performance_monitor;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cp_write, cp_read, cp_priv, cp_rvalid, irq;
    logic [3:0] cp_pri, cp_sec;
    logic [31:0] cp_wdata, cp_rdata;
    logic [255:0] events;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] exp_evt [4] = '{32'h0, 32'h8, 32'h0, 32'h1};
    always #2.5 mclk_i = ~mclk_i;
    cpm_core_model core_u (.mclk_i(mclk_i), .cp_write_o(cp_write), .cp_read_o(cp_read),
        .cp_privileged_o(cp_priv), .cp_primary_o(cp_pri), .cp_secondary_o(cp_sec),
        .cp_wdata_o(cp_wdata), .cp_events_o(events));
    cpm_monitor dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .cp_write_i(cp_write),
        .cp_read_i(cp_read), .cp_privileged_i(cp_priv), .cp_primary_i(cp_pri),
        .cp_secondary_i(cp_sec), .cp_wdata_i(cp_wdata), .cp_rdata_o(cp_rdata),
        .cp_rvalid_o(cp_rvalid), .event_lines_i(events), .irq_o(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic rd(input logic [3:0] pri, input logic [3:0] sec, input logic [31:0] want);
        core_u.move(1'b0, 1'b1, pri, sec, 32'h0);
        check({31'h0, cp_rvalid}, 32'h1);
        check(cp_rdata, want);
    endtask : rd
    task automatic wr(input logic [3:0] pri, input logic [3:0] sec, input logic [31:0] data);
        core_u.move(1'b1, 1'b1, pri, sec, data);
    endtask : wr
    task automatic irq_is(input logic want);
        @(posedge mclk_i);
        #1;
        check({31'h0, irq}, {31'h0, want});
    endtask : irq_is
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(4'h0, 4'h1, {cpm_pkg::UNIT_ID, 24'h0});
        wr(4'h0, 4'h1, 32'hFFFFFFF0);
        rd(4'h0, 4'h1, {cpm_pkg::UNIT_ID, 24'h0});
        core_u.move(1'b1, 1'b0, 4'h4, 4'h1, 32'h1F);
        core_u.move(1'b0, 1'b0, 4'h0, 4'h1, 32'h0);
        check({31'h0, cp_rvalid}, 32'h0);
        rd(4'h4, 4'h1, 32'h0);
        rd(4'h6, 4'h1, 32'h0);
        $display("test access done");
        wr(4'h1, 4'h1, 32'hFFFFFFFE);
        wr(4'h4, 4'h1, 32'h1);
        wr(4'h0, 4'h1, 32'h1);
        rd(4'h1, 4'h1, 32'hFFFFFFFF);
        rd(4'h1, 4'h1, 32'h1);
        rd(4'h5, 4'h1, 32'h1);
        irq_is(1'b1);
        wr(4'h0, 4'h1, 32'h0);
        irq_is(1'b1);
        wr(4'h5, 4'h1, 32'h0);
        irq_is(1'b1);
        wr(4'h4, 4'h1, 32'h0);
        irq_is(1'b0);
        wr(4'h4, 4'h1, 32'h1);
        irq_is(1'b1);
        wr(4'h5, 4'h1, 32'h1);
        irq_is(1'b0);
        $display("test cycle wrap done");
        wr(4'h0, 4'h1, 32'hD);
        rd(4'h1, 4'h1, 32'h0);
        repeat (70) @(posedge mclk_i);
        rd(4'h1, 4'h1, 32'h1);
        wr(4'h0, 4'h1, 32'h0);
        $display("test divide done");
        // selection changes only while disabled
        wr(4'h2, 4'h2, 32'h77);
        rd(4'h2, 4'h2, 32'h77);
        wr(4'h0, 4'h1, 32'h2);
        wr(4'h8, 4'h1, 32'h04030201);
        rd(4'h8, 4'h1, 32'h04030201);
        wr(4'h0, 4'h2, 32'hFFFFFFFF);
        wr(4'h1, 4'h2, 32'h5);
        wr(4'h0, 4'h1, 32'h1);
        @(posedge mclk_i);
        core_u.cp_events_o[1] <= 1'b1;
        core_u.cp_events_o[2] <= 1'b1;
        core_u.cp_events_o[4] <= 1'b1;
        @(posedge mclk_i);
        core_u.cp_events_o[1] <= 1'b0;
        core_u.cp_events_o[4] <= 1'b0;
        repeat (2) @(posedge mclk_i);
        core_u.cp_events_o[2] <= 1'b0;
        wr(4'h0, 4'h1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), 4'h2, exp_evt[i]);
        end
        rd(4'h5, 4'h1, 32'h2);
        irq_is(1'b0);
        @(posedge mclk_i);
        core_u.cp_events_o[2] <= 1'b1;
        repeat (3) @(posedge mclk_i);
        core_u.cp_events_o[2] <= 1'b0;
        rd(4'h1, 4'h2, 32'h8);
        $display("test events done");
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge mclk_i);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : tb_core_performance_monitor
bind cpm_monitor cpm_monitor_checker chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .cp_write_i(cp_write_i), .cp_read_i(cp_read_i), .cp_privileged_i(cp_privileged_i),
    .cp_primary_i(cp_primary_i), .cp_secondary_i(cp_secondary_i),
    .cp_rdata_o(cp_rdata_o), .cp_rvalid_o(cp_rvalid_o), .irq_o(irq_o));
